// ---- src/intctl_defines.vh ----
`ifndef INTCTL_DEFINES_VH
`define INTCTL_DEFINES_VH
`define NSRC            11
`define SRC_PWD         0
`define SRC_SEL         1
`define SRC_LVL1        2
`define SRC_LVL0        3
`define SRC_SP0T        4
`define SRC_SP0R        5
`define SRC_EDGE        6
`define SRC_BYTE_MEMORY_DMA        7
`define SRC_SP1T        8
`define SRC_SP1R        9
`define SRC_TMR         10
`define VEC_RESET       14'h0000
`define VEC_PWD         14'h002C
`define VEC_BASE        14'h0004
`define VEC_STEP        14'h0004
`define ADDR_MASK       8'h00
`define ADDR_CTRL       8'h04
`define ADDR_FC         8'h08
`define ADDR_CMD        8'h0C
`define ADDR_STAT       8'h10
`define ADDR_PEND       8'h14
`define CTRL_SEL_EDGE   0
`define CTRL_ALT0_EDGE  1
`define CTRL_ALT1_EDGE  2
`define CTRL_NEST       4
`define CTRL_ALTSRC     5
`define CTRL_XTAL_OFF   6
`define CTRL_POWERUP_CONTEXT_RESET_BIT       7
`define CMD_ENA         0
`define CMD_DIS         1
`define CMD_IDLE        2
`define CMD_PDOWN       3
`define CMD_RTI         4
`define CMD_PWDFORCE    5
`define CMD_DIV_LSB     8
`define FAST_WAKE_CYC   200
`define XTAL_WAKE_CYC   4096
`define STACK_DEPTH     12
`endif

// ---- src/interrupt_and_low_power_control.v ----
`timescale 1ns/100ps
`include "intctl_defines.vh"
module interrupt_and_low_power_control
#(
  parameter FAST_WAKE = `FAST_WAKE_CYC,
  parameter XTAL_WAKE = `XTAL_WAKE_CYC
)
(
  input  wire        SYS_CLK,            // Processor cycle clock
  input  wire        SYS_RST,            // Asynchronous reset, active high
  input  wire        PSEL,               // APB select
  input  wire        PENABLE,            // APB access phase
  input  wire        PWRITE,             // APB direction
  input  wire [7:0]  PADDR,              // APB byte address
  input  wire [31:0] PWDATA,             // APB write data
  output reg  [31:0] PRDATA,             // APB read data
  output wire        PREADY,             // APB ready
  output wire        PSLVERR,            // APB error on unmapped address
  input  wire        SELECTABLE_SENSE_REQUEST_N, // Pin, active low
  input  wire        LEVEL_REQUEST_ONE_N,  // Pin, active low
  input  wire        LEVEL_REQUEST_ZERO_N, // Pin, active low
  input  wire        EDGE_REQUEST_N,       // Pin, active low
  input  wire [3:0]  SHARED_FLAG_OUT_N,    // Programmed flag outputs on shared pins
  input  wire        ALT_SERIAL_REQUEST_ZERO_N, // Pin, active low
  input  wire        ALT_SERIAL_REQUEST_ONE_N,  // Pin, active low
  input  wire        POWERDOWN_REQUEST_PIN_N,   // Pin, active low
  input  wire        SERIAL_PORT_ZERO_TX,  // Internal pulse
  input  wire        SERIAL_PORT_ZERO_RX,  // Internal pulse
  input  wire        SERIAL_PORT_ONE_TX,   // Internal pulse
  input  wire        SERIAL_PORT_ONE_RX,   // Internal pulse
  input  wire        BYTE_MEMORY_DMA_DONE, // Internal pulse
  input  wire        TIMER_EXPIRED,        // Internal pulse
  input  wire        VECTOR_ACCEPT,        // Sequencer takes vector, pulse
  output reg         VECTOR_VALID,         // Vector request to sequencer
  output reg  [13:0] VECTOR_ADDR,          // Vector word address
  output reg         STATUS_PUSH,          // Status stack push pulse
  output reg         STATUS_POP,           // Status stack pop pulse
  output reg         STACK_OVERFLOW,       // Push with full stack
  output reg         CORE_RUN,             // Instruction execution allowed
  output reg         CONTEXT_CLEAR,        // Clean restart pulse after wake
  output reg         POWERDOWN_ACKNOWLEDGE_PIN, // High while powered down
  output reg         CLOCK_SLOW_TICK       // Divided clock enable for slow idle
);
  localparam ST_RUN  = 4'b0001;
  localparam ST_IDLE = 4'b0010;
  localparam ST_PDN  = 4'b0100;
  localparam ST_WAKE = 4'b1000;

  reg  [8:0]  in_s1, in_s2, in_s3;
  reg  [10:0] interrupt_enable_bits;
  reg  [7:0]  interrupt_sense_nesting_ctrl;
  reg  [10:0] pending;
  reg  [10:0] active;
  reg         global_en;
  reg         mask_holdoff;
  reg  [3:0]  state;
  reg  [12:0] wake_cnt;
  reg  [7:0]  div_n;
  reg  [7:0]  div_cnt;
  reg  [3:0]  sp;
  reg  [10:0] set_ev;
  reg  [10:0] level_req;
  reg  [10:0] eligible;
  reg  [3:0]  win;
  reg         found;
  integer     i;

  wire wr = PSEL & PENABLE & PWRITE;
  wire rd_ok = (PADDR == `ADDR_MASK) | (PADDR == `ADDR_CTRL) | (PADDR == `ADDR_FC) |
               (PADDR == `ADDR_CMD) | (PADDR == `ADDR_STAT) | (PADDR == `ADDR_PEND);
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~rd_ok;

  // Pins pass two flip-flops; the third stage is for edge detection only.
  wire [8:0] raw = {~POWERDOWN_REQUEST_PIN_N, ~ALT_SERIAL_REQUEST_ONE_N,
                    ~ALT_SERIAL_REQUEST_ZERO_N, ~SHARED_FLAG_OUT_N[0] | ~EDGE_REQUEST_N,
                    ~SHARED_FLAG_OUT_N[1] | ~LEVEL_REQUEST_ZERO_N,
                    ~SHARED_FLAG_OUT_N[2] | ~LEVEL_REQUEST_ONE_N,
                    ~SHARED_FLAG_OUT_N[3] | ~SELECTABLE_SENSE_REQUEST_N, 2'b00};
  always @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      in_s1 <= 9'h000;
      in_s2 <= 9'h000;
      in_s3 <= 9'h000;
    end
    else
    begin
      in_s1 <= raw;
      in_s2 <= in_s1;
      in_s3 <= in_s2;
    end
  end
  wire [8:0] rise = in_s2 & ~in_s3;
  wire alt = interrupt_sense_nesting_ctrl[`CTRL_ALTSRC];

  wire sw_pwd = wr & (PADDR == `ADDR_CMD) & PWDATA[`CMD_PWDFORCE];
  always @*
  begin
    set_ev = 11'h000;
    level_req = 11'h000;
    set_ev[`SRC_PWD] = rise[8] | sw_pwd;
    if (interrupt_sense_nesting_ctrl[`CTRL_SEL_EDGE])
      set_ev[`SRC_SEL] = rise[2];
    else
      level_req[`SRC_SEL] = in_s2[2];
    level_req[`SRC_LVL1] = in_s2[3];
    level_req[`SRC_LVL0] = in_s2[4];
    set_ev[`SRC_EDGE] = rise[5];
    set_ev[`SRC_SP0T] = SERIAL_PORT_ZERO_TX;
    set_ev[`SRC_SP0R] = SERIAL_PORT_ZERO_RX;
    set_ev[`SRC_BYTE_MEMORY_DMA] = BYTE_MEMORY_DMA_DONE;
    set_ev[`SRC_TMR]  = TIMER_EXPIRED;
    if (alt)
    begin
      if (interrupt_sense_nesting_ctrl[`CTRL_ALT1_EDGE])
        set_ev[`SRC_SP1T] = rise[7];
      else
        level_req[`SRC_SP1T] = in_s2[7];
      if (interrupt_sense_nesting_ctrl[`CTRL_ALT0_EDGE])
        set_ev[`SRC_SP1R] = rise[6];
      else
        level_req[`SRC_SP1R] = in_s2[6];
    end
    else
    begin
      set_ev[`SRC_SP1T] = SERIAL_PORT_ONE_TX;
      set_ev[`SRC_SP1R] = SERIAL_PORT_ONE_RX;
    end
  end

  wire [10:0] fc_set = (wr & (PADDR == `ADDR_FC)) ? PWDATA[26:16] : 11'h000;
  wire [10:0] fc_clr = (wr & (PADDR == `ADDR_FC)) ? PWDATA[10:0]  : 11'h000;
  wire [10:0] requests = pending | level_req;
  wire [10:0] nmi_bit = 11'h001 << `SRC_PWD;

  // Highest-priority active handler bounds what may preempt when nesting.
  always @*
  begin
    eligible = requests & (interrupt_enable_bits | nmi_bit);
    for (i = 0; i < `NSRC; i = i + 1)
      if (interrupt_sense_nesting_ctrl[`CTRL_NEST] ? active[i] : (active != 11'h000))
        eligible = eligible & ((11'h001 << i) - 11'h001);
    found = 1'b0;
    win = 4'h0;
    for (i = `NSRC - 1; i >= 0; i = i - 1)
      if (eligible[i])
      begin
        found = 1'b1;
        win = i[3:0];
      end
  end

  wire can_take = found & global_en & ~mask_holdoff & ~VECTOR_VALID &
                  (state != ST_PDN) & (state != ST_WAKE);
  wire slow_ok = (div_n == 8'h00) | CLOCK_SLOW_TICK;
  wire [13:0] vec = (win == `SRC_PWD) ? `VEC_PWD :
                    `VEC_BASE + `VEC_STEP * {10'h000, win - 4'h1};
  wire [10:0] taken = (VECTOR_VALID & VECTOR_ACCEPT) ? (11'h001 << win) : 11'h000;
  wire [10:0] win_bit = 11'h001 << win;

  always @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      interrupt_enable_bits <= 11'h000;
      interrupt_sense_nesting_ctrl <= 8'h00;
      pending <= 11'h000;
      active <= 11'h000;
      global_en <= 1'b1;
      mask_holdoff <= 1'b0;
      state <= ST_RUN;
      wake_cnt <= 13'h0000;
      div_n <= 8'h00;
      div_cnt <= 8'h00;
      sp <= 4'h0;
      VECTOR_VALID <= 1'b0;
      VECTOR_ADDR <= `VEC_RESET;
      STATUS_PUSH <= 1'b0;
      STATUS_POP <= 1'b0;
      STACK_OVERFLOW <= 1'b0;
      CORE_RUN <= 1'b1;
      CONTEXT_CLEAR <= 1'b0;
      POWERDOWN_ACKNOWLEDGE_PIN <= 1'b0;
      CLOCK_SLOW_TICK <= 1'b0;
    end
    else
    begin
      STATUS_PUSH <= 1'b0;
      STATUS_POP <= 1'b0;
      CONTEXT_CLEAR <= 1'b0;
      mask_holdoff <= wr & (PADDR == `ADDR_MASK);
      if (wr & (PADDR == `ADDR_MASK))
        interrupt_enable_bits <= PWDATA[10:0];
      if (wr & (PADDR == `ADDR_CTRL))
        interrupt_sense_nesting_ctrl <= PWDATA[7:0];
      // Hardware set wins over a clear in the same cycle.
      pending <= ((pending & ~fc_clr & ~taken) | fc_set | set_ev);
      if (div_n != 8'h00 && div_cnt >= div_n - 8'h01)
      begin
        div_cnt <= 8'h00;
        CLOCK_SLOW_TICK <= 1'b1;
      end
      else
      begin
        div_cnt <= div_cnt + 8'h01;
        CLOCK_SLOW_TICK <= 1'b0;
      end
      if (VECTOR_VALID & VECTOR_ACCEPT)
      begin
        VECTOR_VALID <= 1'b0;
        active <= active | taken;
        STATUS_PUSH <= 1'b1;
        if (sp == `STACK_DEPTH)
          STACK_OVERFLOW <= 1'b1;
        else
          sp <= sp + 4'h1;
      end
      else if (can_take & (state != ST_IDLE | slow_ok))
      begin
        VECTOR_VALID <= 1'b1;
        VECTOR_ADDR <= vec;
        if (state == ST_IDLE)
        begin
          state <= ST_RUN;
          div_n <= 8'h00;
          CORE_RUN <= 1'b1;
        end
      end
      if (wr & (PADDR == `ADDR_CMD))
      begin
        if (PWDATA[`CMD_ENA])
          global_en <= 1'b1;
        if (PWDATA[`CMD_DIS])
          global_en <= 1'b0;
        if (PWDATA[`CMD_RTI] && active != 11'h000)
        begin
          for (i = 0; i < `NSRC; i = i + 1)
            if (active[i] && (active & ((11'h001 << i) - 11'h001)) == 11'h000)
              active[i] <= 1'b0;
          STATUS_POP <= 1'b1;
          if (sp != 4'h0)
            sp <= sp - 4'h1;
        end
        if (PWDATA[`CMD_IDLE] && state == ST_RUN)
        begin
          state <= ST_IDLE;
          CORE_RUN <= 1'b0;
          div_n <= PWDATA[15:8];
          div_cnt <= 8'h00;
        end
        if (PWDATA[`CMD_PDOWN] && state == ST_RUN)
        begin
          state <= ST_PDN;
          CORE_RUN <= 1'b0;
          POWERDOWN_ACKNOWLEDGE_PIN <= 1'b1;
        end
      end
      if (state == ST_PDN && (rise[8] | sw_pwd))
      begin
        state <= ST_WAKE;
        wake_cnt <= interrupt_sense_nesting_ctrl[`CTRL_XTAL_OFF] ?
                    XTAL_WAKE[12:0] : FAST_WAKE[12:0];
      end
      if (state == ST_WAKE)
      begin
        if (wake_cnt <= 13'h0001)
        begin
          state <= ST_RUN;
          CORE_RUN <= 1'b1;
          POWERDOWN_ACKNOWLEDGE_PIN <= 1'b0;
          if (interrupt_sense_nesting_ctrl[`CTRL_POWERUP_CONTEXT_RESET_BIT])
          begin
            CONTEXT_CLEAR <= 1'b1;
            active <= 11'h000;
            sp <= 4'h0;
            VECTOR_VALID <= 1'b1;
            VECTOR_ADDR <= `VEC_RESET;
          end
        end
        else
          wake_cnt <= wake_cnt - 13'h0001;
      end
    end
  end

  always @*
  begin
    case (PADDR)
      `ADDR_MASK: PRDATA = {21'h000000, interrupt_enable_bits};
      `ADDR_CTRL: PRDATA = {24'h000000, interrupt_sense_nesting_ctrl};
      `ADDR_STAT: PRDATA = {16'h0000, div_n, sp, state};
      `ADDR_PEND: PRDATA = {5'h00, active, 5'h00, requests};
      default:    PRDATA = 32'h0000_0000;
    endcase
  end
endmodule

// ---- test/intctl_props.sv ----
`timescale 1ns/100ps
module intctl_props (
  input wire        SYS_CLK,                   // clock
  input wire        SYS_RST,                   // reset
  input wire        PSEL,                      // select
  input wire        PENABLE,                   // access
  input wire        PWRITE,                    // direction
  input wire [7:0]  PADDR,                     // address
  input wire [31:0] PRDATA,                    // read data
  input wire        VECTOR_ACCEPT,             // taken
  input wire        VECTOR_VALID,              // offered
  input wire [13:0] VECTOR_ADDR,               // vector
  input wire        STATUS_PUSH,               // push
  input wire        CORE_RUN,                  // running
  input wire        POWERDOWN_ACKNOWLEDGE_PIN, // asleep
  input wire        CLOCK_SLOW_TICK            // slow tick
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SYS_RST);
  a_push_after_accept:
    assert property (VECTOR_VALID && VECTOR_ACCEPT |=> STATUS_PUSH && !VECTOR_VALID)
      else $error("no push after accept");
  a_push_has_cause:
    assert property (STATUS_PUSH |-> $past(VECTOR_VALID && VECTOR_ACCEPT))
      else $error("push without accept");
  a_vector_holds:
    assert property (VECTOR_VALID && !VECTOR_ACCEPT |=> VECTOR_VALID && $stable(VECTOR_ADDR))
      else $error("vector dropped early");
  a_vector_table:
    assert property (VECTOR_VALID |-> VECTOR_ADDR[1:0] == 2'h0 && VECTOR_ADDR <= 14'h002C)
      else $error("vector off table");
  a_fc_reads_zero:
    assert property (PSEL && PENABLE && !PWRITE && PADDR == 8'h08 |-> PRDATA == 32'h0)
      else $error("force clear readable");
  a_ack_halts_core:
    assert property (POWERDOWN_ACKNOWLEDGE_PIN |-> !CORE_RUN)
      else $error("core runs while asleep");
  a_reset_state:
    assert property ($past(SYS_RST) |-> CORE_RUN && !POWERDOWN_ACKNOWLEDGE_PIN)
      else $error("bad state after reset");
  a_slow_tick_gap:
    assert property (CLOCK_SLOW_TICK |=> !CLOCK_SLOW_TICK [*8])
      else $error("slow ticks too close");
endmodule
bind interrupt_and_low_power_control intctl_props i_props (
  .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PRDATA(PRDATA), .VECTOR_ACCEPT(VECTOR_ACCEPT), .VECTOR_VALID(VECTOR_VALID),
  .VECTOR_ADDR(VECTOR_ADDR), .STATUS_PUSH(STATUS_PUSH), .CORE_RUN(CORE_RUN),
  .POWERDOWN_ACKNOWLEDGE_PIN(POWERDOWN_ACKNOWLEDGE_PIN), .CLOCK_SLOW_TICK(CLOCK_SLOW_TICK));

// ---- test/seq_model.sv ----
`timescale 1ns/100ps
module seq_model (
  input  wire       clk,    // clock
  input  wire       rst,    // reset
  input  wire       valid,  // vector offered
  input  wire [1:0] delay,  // answer delay
  output reg        accept  // vector taken
);
  reg [1:0] cnt;
  // Takes each offered vector after a variable delay, one pulse per vector.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= 2'h0;
      accept <= 1'b0;
    end
    else if (valid && !accept)
    begin
      accept <= cnt == delay;
      cnt <= (cnt == delay) ? 2'h0 : cnt + 2'h1;
    end
    else
      accept <= 1'b0;
  end
endmodule

// ---- test/tb_interrupt_and_low_power_control.sv ----
`timescale 1ns/100ps
module tb_interrupt_and_low_power_control;
  reg          clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
  reg  [7:0]   padr = 0;
  reg  [31:0]  powerdown_request_pin = 0, seed = 12526, rd, m;
  wire [31:0]  prd;
  wire         prdy, perr, vv, acc, run, ack, tick;
  wire [13:0]  va;
  reg  [5:0]   pls = 0;
  reg  [3:0]   flag_n = 4'hF;
  reg          lvl1_n = 1, pwd_n = 1, err, edge_n = 1;
  reg  [1:0]   dly = 0;
  reg  [10:0]  pv;
  logic [13:0] got[$];
  integer      errors = 0, tests_run = 0, k, r, i, n;
  interrupt_and_low_power_control #(.XTAL_WAKE(16)) i_dut (
    .SYS_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(padr),
    .PWDATA(powerdown_request_pin), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
    .SELECTABLE_SENSE_REQUEST_N(1'b1), .LEVEL_REQUEST_ONE_N(lvl1_n),
    .LEVEL_REQUEST_ZERO_N(1'b1), .EDGE_REQUEST_N(edge_n), .SHARED_FLAG_OUT_N(flag_n),
    .ALT_SERIAL_REQUEST_ZERO_N(1'b1), .ALT_SERIAL_REQUEST_ONE_N(1'b1),
    .POWERDOWN_REQUEST_PIN_N(pwd_n), .SERIAL_PORT_ZERO_TX(pls[0]),
    .SERIAL_PORT_ZERO_RX(pls[1]), .BYTE_MEMORY_DMA_DONE(pls[2]), .SERIAL_PORT_ONE_TX(pls[3]),
    .SERIAL_PORT_ONE_RX(pls[4]), .TIMER_EXPIRED(pls[5]), .VECTOR_ACCEPT(acc),
    .VECTOR_VALID(vv), .VECTOR_ADDR(va), .STATUS_PUSH(), .STATUS_POP(), .STACK_OVERFLOW(),
    .CORE_RUN(run), .CONTEXT_CLEAR(), .POWERDOWN_ACKNOWLEDGE_PIN(ack), .CLOCK_SLOW_TICK(tick));
  seq_model i_seq (.clk(clk), .rst(rst), .valid(vv), .delay(dly), .accept(acc));
  always #5 clk = ~clk;
  always @(posedge clk) if (vv && acc) got.push_back(va);
  function automatic [31:0] xs(input [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task stop_test;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task bust;
    begin
      errors = errors + 1;
      stop_test();
    end
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    begin
      tests_run = tests_run + 1;
      if (g !== e)
      begin
        errors = errors + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge clk);
      psel <= 1;
      pwr <= w;
      padr <= a;
      powerdown_request_pin <= d;
      @(posedge clk);
      pen <= 1;
      k = 0;
      do
      begin
        @(posedge clk);
        k = k + 1;
      end
      while (prdy !== 1'b1 && k < 20);
      if (k >= 20) bust();
      rd = prd;
      err = perr;
      psel <= 0;
      pen <= 0;
    end
  endtask
  task wv(input logic [13:0] e);
    begin
      k = 0;
      while (got.size() == 0 && k < 3000)
      begin
        @(posedge clk);
        k = k + 1;
      end
      if (got.size() == 0) bust();
      chk(got.pop_front(), e);
    end
  endtask
  task wait_on(input integer s, input logic v);
    begin
      k = 0;
      while ((s ? ack : tick) !== v && k < 1000)
      begin
        @(posedge clk);
        k = k + 1;
      end
      if (k >= 1000) bust();
    end
  endtask
  task pul(input logic [5:0] p);
    begin
      @(posedge clk);
      pls <= p;
      @(posedge clk);
      pls <= 6'h00;
    end
  endtask
  task quiet;
    begin
      repeat (20) @(posedge clk);
    end
  endtask
  task rti;
    apb(1, 8'h0C, 32'h0000_0010);
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 0;
    apb(0, 8'h00, 0);
    chk(rd, 0);
    chk(run, 1);
    apb(0, 8'h40, 0);
    chk(err, 1);
    apb(0, 8'h08, 0);
    chk(rd, 0);
    $display("test reset done");
    for (r = 0; r < 8; r = r + 1)
    begin
      seed = xs(seed);
      m = seed & 32'h0000_07FF;
      dly = seed[13:12];
      apb(1, 8'h00, m);
      seed = xs(seed);
      pul(seed[5:0]);
      pv = {seed[5:2], 1'b0, seed[1:0], 4'h0};
      for (i = 1; i < 11; i = i + 1)
        if (pv[i] && m[i])
        begin
          wv(14'(4 * i));
          rti();
        end
      apb(1, 8'h08, 32'h0000_07FF);
      quiet();
      chk(got.size(), 0);
    end
    $display("test priority done");
    apb(1, 8'h00, 32'h0000_07FF);
    apb(1, 8'h0C, 32'h0000_0002);
    pul(6'h20);
    quiet();
    chk(got.size(), 0);
    apb(1, 8'h0C, 32'h0000_0001);
    wv(14'h0028);
    rti();
    apb(1, 8'h08, 32'h0040_0000);
    wv(14'h0018);
    rti();
    quiet();
    chk(got.size(), 0);
    lvl1_n <= 0;
    wv(14'h0008);
    lvl1_n <= 1;
    quiet();
    rti();
    edge_n <= 0;
    wv(14'h0018);
    edge_n <= 1;
    rti();
    quiet();
    chk(got.size(), 0);
    flag_n <= 4'hD;
    wv(14'h000C);
    flag_n <= 4'hF;
    quiet();
    rti();
    apb(1, 8'h04, 32'h0000_0010);
    pul(6'h20);
    wv(14'h0028);
    pul(6'h01);
    wv(14'h0010);
    rti();
    rti();
    apb(1, 8'h04, 0);
    $display("test sources done");
    for (n = 16; n <= 128; n = n * 2)
    begin
      apb(1, 8'h0C, 32'h0000_0004 | (n << 8));
      wait_on(0, 1);
      @(posedge clk);
      wait_on(0, 1);
      chk(k + 1, n);
      pul(6'h20);
      wv(14'h0028);
      rti();
    end
    $display("test idle done");
    apb(1, 8'h00, 0);
    pwd_n <= 0;
    wv(14'h002C);
    rti();
    pwd_n <= 1;
    apb(1, 8'h0C, 32'h0000_0008);
    wait_on(1, 1);
    pwd_n <= 0;
    wait_on(1, 0);
    chk(k > 150 && k < 260, 1);
    pwd_n <= 1;
    quiet();
    got.delete();
    apb(1, 8'h0C, 32'h0000_0008);
    wait_on(1, 1);
    rst <= 1;
    @(posedge clk);
    rst <= 0;
    @(posedge clk);
    chk({ack, run}, 2'h1);
    $display("test powerdown done");
    stop_test();
  end
endmodule
